// ---- hmw_mem_model.sv ----
// Behavioural internal memory that answers the window's memory port.
`timescale 1ns/1ps
module hmw_mem_model (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Memory port.
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        slow_i,
  output logic      [31:0] rdata_o,
  output logic             ack_o
);
  logic [31:0] mem [0:255];
  logic [2:0]  wait_cnt;

  // Read data is only valid with the acknowledge; otherwise it shows the inverse.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o    <= 1'b0;
      wait_cnt <= 3'h0;
      rdata_o  <= 32'h0;
    end else if (ack_o) begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
    end else if (req_i && wait_cnt >= (slow_i ? 3'h4 : 3'h0)) begin
      ack_o    <= 1'b1;
      wait_cnt <= 3'h0;
      rdata_o  <= mem[addr_i[9:2]];
    end else if (req_i) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end

  // Storage sits in a plain process so that the bench may preload words directly.
  always @(posedge clock_i) begin
    if (rstn_i && !ack_o && req_i && wait_cnt >= (slow_i ? 3'h4 : 3'h0)) begin
      for (int b = 0; b < 4; b++) begin
        if (we_i && be_i[b]) mem[addr_i[9:2]][8*b +: 8] <= wdata_i[8*b +: 8];
      end
    end
  end
endmodule // hmw_mem_model

// ---- hmw_pkg.sv ----
// Constants for the host memory window unit.
package hmw_pkg;
  localparam logic [3:0] REG_H2C      = 4'h0;
  localparam logic [3:0] REG_C2H      = 4'h1;
  localparam logic [3:0] REG_ADDR_LO  = 4'h2;
  localparam logic [3:0] REG_ADDR_HI  = 4'h3;
  localparam logic [3:0] REG_DATA0    = 4'h4;
  localparam logic [3:0] REG_DATA3    = 4'h7;
  localparam logic [3:0] REG_SRC_LO   = 4'h8;
  localparam logic [3:0] REG_SRC_HI   = 4'h9;
  localparam logic [3:0] REG_MASK_LO  = 4'ha;
  localparam logic [3:0] REG_MASK_HI  = 4'hb;
  localparam logic [3:0] REG_APP_ID   = 4'hc;
  // Access size field, low two bits of the window address.
  localparam logic [1:0] SIZE_BYTE    = 2'h0;
  localparam logic [1:0] SIZE_HALF    = 2'h1;
  localparam logic [1:0] SIZE_WORD    = 2'h2;
  localparam logic [1:0] SIZE_AUTO    = 2'h3;
  localparam int         REGION_BIT   = 15;
  localparam int         SWI_W        = 15;
  localparam logic [1:0] LANE_LAST    = 2'h3;
  localparam logic [3:0] BE_NONE      = 4'h0;
  localparam logic [3:0] BE_LOW       = 4'h3;
  localparam logic [3:0] BE_HIGH      = 4'hc;
  localparam logic [3:0] BE_ALL       = 4'hf;
  localparam logic [3:0] BE_ONE       = 4'h1;
  localparam logic [15:0] ADDR_RST    = 16'h0000;
  localparam logic [15:0] MASK_RST    = 16'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
endpackage

// ---- hmw_top.sv ----
// Host to controller mailbox, software events and byte-wide memory window.
`timescale 1ns/1ps
// Functional notes
// - Host write of host-to-controller mailbox raises controller interrupt.
// - Controller write of controller-to-host mailbox raises mailbox host source.
// - Software event asserts on enabled event bit or controller mailbox write.
// - Host event output is low while mailbox source or software event asserts.
// - Each host event can be masked by the mask register.
// - Host reads which event caused the interrupt from the source register.
// - System reset returns all registers and state to defaults.
// - Host and controller accesses each complete in their own clock timing.
// - Unit idles in low power when nothing addresses it.
// - Thirteen host byte registers; controller-only settings elsewhere.
// - Controller sets regions read-only, write-only or read/write for host.
// - Base and limits are controller-only, host cannot see them.
// - Read and write limits independent; regions may overlap.
// - Zero read limit with positive write limit makes region write-only.
// - Two regions, each window at most 32 kilobytes.
// - 16-bit address register and 32-bit data register, byte accessed.
// - Host accesses bytes; memory transfers may be wider.
// - Data byte read loads one, two or four bytes per size field.
// - Data byte write stores matching byte or bytes per size field.
// - Auto-increment advances the address without host rewriting it.
// - Size 00 byte, 01 half, 10 word, 11 word with increment on byte 3.
// - Word mode: byte 0 read fetches, byte 3 write commits all four.
// - Half mode: bytes 0,2 reads fetch; bytes 1,3 writes commit pairs.
// - Write to read-only or no-access area updates only data register.
module hmw_top
  import hmw_pkg::*;
(
  // Clock, enable and reset.
  input  wire logic              clock_i,
  input  wire logic              ce_i,
  input  wire logic              rstn_i,
  // Host byte port, asynchronous to clock_i.
  input  wire logic              host_clk_i,
  input  wire logic              host_sel_i,
  input  wire logic              host_wr_i,
  input  wire logic [3:0]        host_addr_i,
  input  wire logic [7:0]        host_wdata_i,
  output logic      [7:0]        host_rdata_o,
  output logic                   host_busy_o,
  output logic                   host_event_out_n_o,
  // Controller side.
  input  wire logic              ec_mbox_wr_i,
  input  wire logic [7:0]        ec_mbox_data_i,
  input  wire logic              ec_h2c_ack_i,
  input  wire logic [SWI_W-1:0]  software_event_bits_set_i,
  input  wire logic [SWI_W-1:0]  software_event_enables_i,
  input  wire logic [1:0][31:0]  region_base_i,
  input  wire logic [1:0][14:0]  region_rd_limit_i,
  input  wire logic [1:0][14:0]  region_wr_limit_i,
  output logic      [7:0]        h2c_mbox_o,
  output logic                   h2c_irq_o,
  output logic      [SWI_W-1:0]  software_event_bits_o,
  output logic      [7:0]        app_id_o,
  output logic                   idle_o,
  // Internal memory port.
  output logic                   mem_req_o,
  output logic                   mem_we_o,
  output logic      [31:0]       mem_addr_o,
  output logic      [3:0]        mem_be_o,
  output logic      [31:0]       mem_wdata_o,
  input  wire logic [31:0]       mem_rdata_i,
  input  wire logic              mem_ack_i
);

  typedef enum logic {ST_IDLE, ST_MEM} hmw_state_t;

  // Lanes moved to or from memory for an access of data byte lane.
  function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] lane,
                                           input logic wr);
    logic [3:0] m;
    m = BE_NONE;
    unique case (size)
      SIZE_BYTE: m = BE_ONE << lane;
      SIZE_HALF: begin
        if (wr && lane == 2'h1) m = BE_LOW;
        if (wr && lane == LANE_LAST) m = BE_HIGH;
        if (!wr && lane == 2'h0) m = BE_LOW;
        if (!wr && lane == 2'h2) m = BE_HIGH;
      end
      SIZE_WORD, SIZE_AUTO: begin
        if (wr && lane == LANE_LAST) m = BE_ALL;
        if (!wr && lane == 2'h0) m = BE_ALL;
      end
    endcase
    return m;
  endfunction

  // Host port synchronisers; a three-bit history finds host clock edges.
  logic [12:0] sync1;
  logic [12:0] sync2;
  logic        hclk_d;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1  <= '0;
      sync2  <= '0;
      hclk_d <= 1'b0;
    end else if (ce_i) begin
      sync1  <= {host_clk_i, host_sel_i, host_wr_i, host_addr_i, host_wdata_i[7:2]};
      sync2  <= sync1;
      hclk_d <= sync2[12];
    end
  end
  logic [1:0] wlo1;
  logic [1:0] wlo2;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wlo1 <= 2'h0;
      wlo2 <= 2'h0;
    end else if (ce_i) begin
      wlo1 <= host_wdata_i[1:0];
      wlo2 <= wlo1;
    end
  end

  hmw_state_t       state;
  logic [15:0]      addr_q;
  logic [3:0][7:0]  data_q;
  logic [3:0]       be_q;
  logic [1:0]       lane_q;
  logic             mbox_src;
  logic [SWI_W-1:0] swi;
  logic [15:0]      mask;
  logic [7:0]       c2h_mbox;

  logic       acc;
  logic       acc_wr;
  logic [3:0] acc_addr;
  logic [7:0] acc_data;
  assign acc      = sync2[12] && !hclk_d && sync2[11] && state == ST_IDLE;
  assign acc_wr   = acc && sync2[10];
  assign acc_addr = sync2[9:6];
  assign acc_data = {sync2[5:0], wlo2};

  // Window decode against the selected region.
  logic        rsel;
  logic [14:0] win_off;
  logic        rd_ok;
  logic        wr_ok;
  logic        is_data;
  logic [1:0]  lane;
  logic [1:0]  size;
  logic [3:0]  be;
  assign rsel    = addr_q[REGION_BIT];
  assign win_off = {addr_q[14:2], 2'h0};
  assign rd_ok   = win_off < region_rd_limit_i[rsel];
  assign wr_ok   = win_off < region_wr_limit_i[rsel];
  assign is_data = acc_addr >= REG_DATA0 && acc_addr <= REG_DATA3;
  assign lane    = acc_addr[1:0];
  assign size    = addr_q[1:0];
  assign be      = lane_mask(size, lane, acc_wr);

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = BYTE_RST;
    unique case (acc_addr)
      REG_H2C:     next_rdata = h2c_mbox_o;
      REG_C2H:     next_rdata = c2h_mbox;
      REG_ADDR_LO: next_rdata = addr_q[7:0];
      REG_ADDR_HI: next_rdata = addr_q[15:8];
      REG_SRC_LO:  next_rdata = {swi[6:0], mbox_src};
      REG_SRC_HI:  next_rdata = swi[14:7];
      REG_MASK_LO: next_rdata = mask[7:0];
      REG_MASK_HI: next_rdata = mask[15:8];
      REG_APP_ID:  next_rdata = app_id_o;
      default:     next_rdata = data_q[lane];
    endcase
  end

  // Window engine: address, data register and memory transfers.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state        <= ST_IDLE;
      addr_q       <= ADDR_RST;
      data_q       <= '0;
      be_q         <= BE_NONE;
      lane_q       <= 2'h0;
      host_rdata_o <= BYTE_RST;
      mem_req_o    <= 1'b0;
      mem_we_o     <= 1'b0;
      mem_addr_o   <= '0;
      mem_be_o     <= BE_NONE;
      mem_wdata_o  <= '0;
    end else if (ce_i) begin
      unique case (state)
        ST_IDLE: begin
          if (acc && !acc_wr) host_rdata_o <= next_rdata;
          if (acc_wr && acc_addr == REG_ADDR_LO) addr_q[7:0] <= acc_data;
          if (acc_wr && acc_addr == REG_ADDR_HI) addr_q[15:8] <= acc_data;
          if (acc && is_data) begin
            lane_q     <= lane;
            be_q       <= be;
            mem_addr_o <= region_base_i[rsel] + {17'h0, win_off};
            mem_we_o   <= acc_wr;
            mem_be_o   <= be;
            if (acc_wr) begin
              data_q[lane] <= acc_data;
              mem_wdata_o  <= data_q;
              mem_wdata_o[lane*8 +: 8] <= acc_data;
            end
            if (be != BE_NONE && (acc_wr ? wr_ok : rd_ok)) begin
              mem_req_o <= 1'b1;
              state     <= ST_MEM;
            end
            if (size == SIZE_AUTO && lane == LANE_LAST && (!acc_wr || wr_ok))
              addr_q[14:2] <= addr_q[14:2] + 13'h1;
          end
        end
        ST_MEM: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            state     <= ST_IDLE;
            if (!mem_we_o) begin
              for (int i = 0; i < 4; i++)
                if (be_q[i]) data_q[i] <= mem_rdata_i[i*8 +: 8];
              host_rdata_o <= mem_rdata_i[lane_q*8 +: 8];
            end
          end
        end
      endcase
    end
  end

  // Mailboxes, software events, mask and ownership ID.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      h2c_mbox_o <= BYTE_RST;
      h2c_irq_o  <= 1'b0;
      c2h_mbox   <= BYTE_RST;
      mbox_src   <= 1'b0;
      swi        <= '0;
      mask       <= MASK_RST;
      app_id_o   <= BYTE_RST;
    end else if (ce_i) begin
      if (acc_wr && acc_addr == REG_H2C) h2c_mbox_o <= acc_data;
      if (acc_wr && acc_addr == REG_H2C) h2c_irq_o <= 1'b1;
      else if (ec_h2c_ack_i) h2c_irq_o <= 1'b0;
      if (ec_mbox_wr_i) c2h_mbox <= ec_mbox_data_i;
      if (ec_mbox_wr_i) mbox_src <= 1'b1;
      else if (acc_wr && acc_addr == REG_SRC_LO && acc_data[0]) mbox_src <= 1'b0;
      swi <= (swi & ~((acc_wr && acc_addr == REG_SRC_LO) ? {8'h0, acc_data[7:1]} : '0)
                  & ~((acc_wr && acc_addr == REG_SRC_HI) ? {acc_data, 7'h0} : '0))
             | software_event_bits_set_i;
      if (acc_wr && acc_addr == REG_MASK_LO) mask[7:0] <= acc_data;
      if (acc_wr && acc_addr == REG_MASK_HI) mask[15:8] <= acc_data;
      if (acc_wr && acc_addr == REG_APP_ID) app_id_o <= acc_data;
    end
  end

  // Host event output and status.
  logic mbox_irq;
  logic host_software_event;
  assign mbox_irq            = mbox_src && !mask[0];
  assign host_software_event = |(swi & software_event_enables_i & ~mask[15:1]) || mbox_irq;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_event_out_n_o    <= 1'b1;
      host_busy_o           <= 1'b0;
      idle_o                <= 1'b1;
      software_event_bits_o <= '0;
    end else if (ce_i) begin
      host_event_out_n_o    <= !(mbox_irq || host_software_event);
      host_busy_o           <= state == ST_MEM || (acc && is_data);
      idle_o                <= state == ST_IDLE && !acc && !sync2[11];
      software_event_bits_o <= swi;
    end
  end

  AST_H2C_IRQ: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && acc_wr && acc_addr == REG_H2C |=> h2c_irq_o)
    else $error("host mailbox write did not raise controller interrupt");
  AST_C2H_SRC: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && ec_mbox_wr_i |=> mbox_src ##0 c2h_mbox == $past(ec_mbox_data_i))
    else $error("controller mailbox write lost");
  AST_EVENT_LOW: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && mbox_src && !mask[0] |=> !host_event_out_n_o)
    else $error("host event not driven low for mailbox");
  AST_SWI_EVENT: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && |(swi & software_event_enables_i & ~mask[15:1]) |=> !host_event_out_n_o)
    else $error("software event did not drive host event");
  AST_MASKED: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && !mbox_irq && (swi & software_event_enables_i & ~mask[15:1]) == '0
    |=> host_event_out_n_o)
    else $error("masked event produced host event");
  AST_NO_COMMIT: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && acc_wr && is_data && !wr_ok |=> !mem_req_o ##0 data_q[$past(lane)] == $past(acc_data))
    else $error("refused write reached memory or missed data register");
  AST_AUTO_INC: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && acc && !acc_wr && is_data && size == SIZE_AUTO && lane == LANE_LAST
    |=> addr_q[14:2] == $past(addr_q[14:2]) + 13'h1)
    else $error("auto increment missed");
  AST_WORD_BE: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && acc && is_data && size == SIZE_WORD && rd_ok && lane == 2'h0 && !acc_wr
    |=> mem_req_o && mem_be_o == BE_ALL && !mem_we_o)
    else $error("word read did not fetch four bytes");
  AST_HALF_HI: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && acc_wr && is_data && size == SIZE_HALF && wr_ok && lane == LANE_LAST
    |=> mem_req_o && mem_be_o == BE_HIGH)
    else $error("half write of byte 3 did not commit upper pair");

endmodule // hmw_top

// ---- test_hmw_top.sv ----
// Self-checking bench for the host memory window unit.
`timescale 1ns/1ps
module test_hmw_top;
  import hmw_pkg::*;
  logic             clock_i = 1'b0;
  logic             rstn_i = 1'b0;
  logic             ce = 1'b1;
  logic             host_clk_i = 1'b0;
  logic             host_sel_i = 1'b0;
  logic             host_wr_i = 1'b0;
  logic [3:0]       host_addr_i = 4'h0;
  logic [7:0]       host_wdata_i = 8'h00;
  logic             ec_mbox_wr_i = 1'b0;
  logic [7:0]       ec_mbox_data_i = 8'h00;
  logic             ec_h2c_ack_i = 1'b0;
  logic [SWI_W-1:0] software_event_bits_set_i = '0;
  logic [SWI_W-1:0] en = 15'h0004;
  logic [1:0][31:0] base = {32'h0000_0200, 32'h0000_0100};
  logic [1:0][14:0] rdl = {15'h0000, 15'h0040};
  logic [1:0][14:0] wrl = {15'h0010, 15'h0010};
  logic [7:0]       h2c, app, rd;
  logic [SWI_W-1:0] swi;
  logic             h2c_irq, busy, ev_n, idle, req, we, ack, slow = 1'b0;
  logic [31:0]      maddr, mwd, mrd;
  logic [3:0]       be;
  int               errors = 0;
  int               samples_checked = 0;

  always #25 clock_i = ~clock_i;

  hmw_top dut_u (.clock_i(clock_i), .ce_i(ce), .rstn_i(rstn_i), .host_clk_i(host_clk_i),
    .host_sel_i(host_sel_i), .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_rdata_o(rd), .host_busy_o(busy),
    .host_event_out_n_o(ev_n), .ec_mbox_wr_i(ec_mbox_wr_i), .ec_mbox_data_i(ec_mbox_data_i),
    .ec_h2c_ack_i(ec_h2c_ack_i), .software_event_bits_set_i(software_event_bits_set_i), .software_event_enables_i(en),
    .region_base_i(base), .region_rd_limit_i(rdl), .region_wr_limit_i(wrl), .h2c_mbox_o(h2c),
    .h2c_irq_o(h2c_irq), .software_event_bits_o(swi), .app_id_o(app), .idle_o(idle),
    .mem_req_o(req), .mem_we_o(we), .mem_addr_o(maddr), .mem_be_o(be), .mem_wdata_o(mwd),
    .mem_rdata_i(mrd), .mem_ack_i(ack));

  hmw_mem_model mem_u (.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req), .we_i(we),
    .addr_i(maddr), .be_i(be), .wdata_i(mwd), .slow_i(slow), .rdata_o(mrd), .ack_o(ack));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One host access: a full 400 ns host clock period, then wait out any memory transfer.
  task automatic host(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(negedge clock_i);
    host_sel_i = 1'b1;
    host_wr_i = wr;
    host_addr_i = a;
    host_wdata_i = d;
    host_clk_i = 1'b1;
    repeat (4) @(negedge clock_i);
    host_clk_i = 1'b0;
    repeat (4) @(negedge clock_i);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    check("busy", 32'h0, {31'h0, busy});
    host_sel_i = 1'b0;
    @(negedge clock_i);
  endtask

  task automatic rdchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    host(1'b0, a, 8'h00);
    check(name, {24'h0, exp}, {24'h0, rd});
  endtask

  task automatic setaddr(input logic [15:0] v);
    host(1'b1, REG_ADDR_LO, v[7:0]);
    host(1'b1, REG_ADDR_HI, v[15:8]);
  endtask

  task automatic wr4(input logic [31:0] w);
    for (int i = 0; i < 4; i++) host(1'b1, REG_DATA0 + 4'(i), w[8*i +: 8]);
  endtask

  task automatic pulse_c2h(input logic [7:0] d);
    @(negedge clock_i);
    ec_mbox_data_i = d;
    ec_mbox_wr_i = 1'b1;
    @(negedge clock_i);
    ec_mbox_wr_i = 1'b0;
    repeat (4) @(negedge clock_i);
  endtask

  task automatic t_mailbox;
    host(1'b1, REG_H2C, 8'ha5);
    check("h2c_mbox", 32'ha5, {24'h0, h2c});
    check("h2c_irq", 32'h1, {31'h0, h2c_irq});
    @(negedge clock_i);
    ec_h2c_ack_i = 1'b1;
    @(negedge clock_i);
    ec_h2c_ack_i = 1'b0;
    repeat (3) @(negedge clock_i);
    check("h2c_irq_clr", 32'h0, {31'h0, h2c_irq});
    pulse_c2h(8'h3c);
    check("event_n_mbox", 32'h0, {31'h0, ev_n});
    rdchk("c2h_mbox", REG_C2H, 8'h3c);
    rdchk("source_mbox", REG_SRC_LO, 8'h01);
    host(1'b1, REG_MASK_LO, 8'h01);
    check("event_n_masked", 32'h1, {31'h0, ev_n});
    host(1'b1, REG_MASK_LO, 8'h00);
    check("event_n_unmasked", 32'h0, {31'h0, ev_n});
    host(1'b1, REG_SRC_LO, 8'h01);
    check("event_n_cleared", 32'h1, {31'h0, ev_n});
  endtask

  task automatic t_swi;
    @(negedge clock_i);
    software_event_bits_set_i = 15'h0024;
    @(negedge clock_i);
    software_event_bits_set_i = 15'h0000;
    repeat (4) @(negedge clock_i);
    check("swi_bits", 32'h24, {17'h0, swi});
    check("event_n_swi", 32'h0, {31'h0, ev_n});
    rdchk("source_swi", REG_SRC_LO, 8'h48);
    host(1'b1, REG_SRC_LO, 8'h08);
    check("event_n_disabled", 32'h1, {31'h0, ev_n});
    host(1'b1, REG_SRC_LO, 8'h40);
    @(negedge clock_i);
    software_event_bits_set_i = 15'h4080;
    @(negedge clock_i);
    software_event_bits_set_i = 15'h0000;
    rdchk("source_hi", REG_SRC_HI, 8'h81);
    host(1'b1, REG_SRC_HI, 8'h01);
    check("swi_hi_clear", 32'h4000, {17'h0, swi});
    host(1'b1, REG_SRC_HI, 8'h80);
    ce = 1'b0;
    software_event_bits_set_i = 15'h0001;
    @(negedge clock_i);
    software_event_bits_set_i = 15'h0000;
    @(negedge clock_i);
    ce = 1'b1;
    repeat (2) @(negedge clock_i);
    check("swi_frozen", 32'h0, {17'h0, swi});
  endtask

  task automatic t_window;
    mem_u.mem[65] = 32'h4433_2211;
    setaddr(16'h0006);
    rdchk("word_fetch", REG_DATA0, 8'h11);
    mem_u.mem[65] = 32'h0;
    rdchk("word_nofetch", REG_DATA3, 8'h44);
    setaddr(16'h0004);
    host(1'b1, 4'h5, 8'h77);
    check("byte_store", 32'h7700, mem_u.mem[65]);
    setaddr(16'h0005);
    host(1'b1, REG_DATA0, 8'haa);
    check("half_nocommit", 32'h7700, mem_u.mem[65]);
    host(1'b1, 4'h5, 8'hbb);
    check("half_commit", 32'hbbaa, mem_u.mem[65]);
    host(1'b1, 4'h6, 8'hcc);
    host(1'b1, REG_DATA3, 8'hdd);
    check("half_commit_hi", 32'hddcc_bbaa, mem_u.mem[65]);
    mem_u.mem[65] = 32'h6655_0000;
    rdchk("half_fetch_hi", 4'h6, 8'h55);
    rdchk("half_fetch_b3", REG_DATA3, 8'h66);
    slow = 1'b1;
    setaddr(16'h0003);
    wr4(32'h0403_0201);
    wr4(32'h0807_0605);
    check("auto_dw0", 32'h0403_0201, mem_u.mem[64]);
    check("auto_dw1", 32'h0807_0605, mem_u.mem[65]);
    slow = 1'b0;
    mem_u.mem[68] = 32'hcafe_f00d;
    setaddr(16'h0012);
    wr4(32'h1234_5678);
    check("read_only", 32'hcafe_f00d, mem_u.mem[68]);
    setaddr(16'h8006);
    wr4(32'h0c0b_0a09);
    check("write_only", 32'h0c0b_0a09, mem_u.mem[129]);
    mem_u.mem[129] = 32'h0;
    rdchk("write_only_rd", REG_DATA0, 8'h09);
    setaddr(16'h0003);
    rdchk("auto_rd0", REG_DATA0, 8'h01);
    rdchk("auto_rd3", REG_DATA3, 8'h04);
    rdchk("auto_rd_addr", REG_ADDR_LO, 8'h07);
  endtask

  task automatic t_reset;
    host(1'b1, REG_APP_ID, 8'h5e);
    check("app_id", 32'h5e, {24'h0, app});
    rdchk("app_id_rd", REG_APP_ID, 8'h5e);
    pulse_c2h(8'h11);
    @(negedge clock_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge clock_i);
    check("rst_app", 32'h0, {24'h0, app});
    check("rst_event_n", 32'h1, {31'h0, ev_n});
    rstn_i = 1'b1;
    repeat (3) @(negedge clock_i);
    check("rst_idle", 32'h1, {31'h0, idle});
    rdchk("rst_c2h", REG_C2H, 8'h00);
  endtask

  initial begin
    #2000000;
    errors++;
    results();
  end

  initial begin
    repeat (10) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check("idle", 32'h1, {31'h0, idle});
    t_mailbox();
    t_swi();
    t_window();
    t_reset();
    results();
  end
endmodule // test_hmw_top
